/* File: hw/asr_regs.vh */
`ifndef ASR_REGS_VH
`define ASR_REGS_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define ASR_X_SAMPLE_LOW      8'h00
`define ASR_X_SAMPLE_HIGH     8'h01
`define ASR_Y_SAMPLE_LOW      8'h02
`define ASR_Y_SAMPLE_HIGH     8'h03
`define ASR_Z_SAMPLE_LOW      8'h04
`define ASR_Z_SAMPLE_HIGH     8'h05
`define ASR_X_SAMPLE_BYTE     8'h06
`define ASR_Y_SAMPLE_BYTE     8'h07
`define ASR_Z_SAMPLE_BYTE     8'h08
`define ASR_SAMPLE_STATE      8'h09
`define ASR_EVENT_SOURCE      8'h0a
`define ASR_BUS_ADDRESS       8'h0d
`define ASR_USER_INFO         8'h0e
`define ASR_PART_IDENT        8'h0f
`define ASR_X_TRIM_LOW        8'h10
`define ASR_X_TRIM_HIGH       8'h11
`define ASR_Y_TRIM_LOW        8'h12
`define ASR_Y_TRIM_HIGH       8'h13
`define ASR_Z_TRIM_LOW        8'h14
`define ASR_Z_TRIM_HIGH       8'h15
`define ASR_MODE_CONTROL      8'h16
`define ASR_FLAG_CLEAR        8'h17
`define ASR_CONTROL_ONE       8'h18

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define ASR_ST_READY_BIT      0
`define ASR_ST_OVER_BIT       1
`define ASR_ST_PARITY_BIT     2
`define ASR_MC_SELF_TEST_BIT  4
`define ASR_MC_READY_MASK_BIT 6
`define ASR_CLR_A_BIT         0
`define ASR_CLR_B_BIT         1
`define ASR_CTL_ROUTE_LSB     1
`define ASR_BA_OFF_BIT        7

// ------------------------------------------------------------
// Reset values and encodings
// ------------------------------------------------------------
`define ASR_SLAVE_ADDR_RST    7'h1d
`define ASR_ROUTE_LVL_PLS     2'h0
`define ASR_ROUTE_PLS_LVL     2'h1
`define ASR_ROUTE_SGL_ANY     2'h2

`endif

/* File: hw/asr_axis_hold.v */
`timescale 1ns/1ps

// ------------------------------------------------------------
// One axis: sample store and coherent high-byte hold
// ------------------------------------------------------------
module asr_axis_hold
(
    core_clk,
    reset_n,
    sample_load,
    sample_in,
    byte_in,
    low_read,
    high_read,
    low_byte,
    high_byte,
    short_byte
);
    input  wire       core_clk;
    input  wire       reset_n;
    input  wire       sample_load;
    input  wire [9:0] sample_in;
    input  wire [7:0] byte_in;
    input  wire       low_read;
    input  wire       high_read;
    output wire [7:0] low_byte;
    output wire [7:0] high_byte;
    output wire [7:0] short_byte;

    reg  [9:0] sample_r;
    reg  [7:0] short_r;
    reg  [1:0] hold_r;
    reg        held_r;

    always @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            sample_r <= 10'h000;
            short_r  <= 8'h00;
            hold_r   <= 2'h0;
            held_r   <= 1'b0;
        end
        else
        begin
            if (sample_load)
            begin
                sample_r <= sample_in;
                short_r  <= byte_in;
            end
            // Low read freezes the top bits of the same sample
            if (low_read)
            begin
                hold_r <= sample_r[9:8];
                held_r <= 1'b1;
            end
            else if (high_read)
            begin
                held_r <= 1'b0;
            end
        end
    end

    assign low_byte   = sample_r[7:0];
    assign high_byte  = {6'h00, (held_r ? hold_r : sample_r[9:8])};
    assign short_byte = short_r;

endmodule // asr_axis_hold

/* File: hw/asr_sample_regs.v */
`timescale 1ns/1ps
`include "asr_regs.vh"

// Contract
// - Axis samples are 10-bit, reset to zero
// - Low-byte read freezes X high byte
// - Y axis latches the same way
// - Z axis latches the same way
// - Each axis has an 8-bit sample
// - Status bit 0 flags new sample set
// - Status bit 1 flags overwritten sample
// - Status bit 2 trim parity, blocks self-test
// - Bits 7..5 flag level hits X,Y,Z
// - Bits 4..2 flag single pulse hits
// - Pulse flags meaningless during double pulse
// - Bits 0,1 flag routed interrupt sources
// - Address bits 6..0 fixed, bit 7 writable
// - Disable bit makes two-wire access ignored
// - User byte comes from programmed storage
// - Identity byte comes from programmed storage
// - Per-axis offset trims, writable, reset zero
// - Trim low bit weighs half a count
// - Ready mask 0 drives ready to pin
// - Routing 00 level/pulse, 01 swapped
// - Clear bits clear flag and its class
module asr_sample_regs
(
    core_clk,
    reset_n,
    reg_addr,
    reg_wr,
    reg_rd,
    reg_wdata,
    reg_two_wire,
    reg_rdata_r,
    reg_rvalid_r,
    sample_valid,
    x_sample,
    y_sample,
    z_sample,
    x_byte_in,
    y_byte_in,
    z_byte_in,
    level_hit,
    pulse_hit,
    pulse_is_double,
    trim_parity_fault,
    otp_user_byte,
    otp_ident_byte,
    int_a_pin_r,
    int_b_pin_r,
    two_wire_off_r,
    self_test_en_r,
    mode_sel_r,
    x_trim_r,
    y_trim_r,
    z_trim_r
);
    input  wire        core_clk;
    input  wire        reset_n;
    input  wire [7:0]  reg_addr;
    input  wire        reg_wr;
    input  wire        reg_rd;
    input  wire [7:0]  reg_wdata;
    input  wire        reg_two_wire;
    output reg  [7:0]  reg_rdata_r;
    output reg         reg_rvalid_r;
    input  wire        sample_valid;
    input  wire [9:0]  x_sample;
    input  wire [9:0]  y_sample;
    input  wire [9:0]  z_sample;
    input  wire [7:0]  x_byte_in;
    input  wire [7:0]  y_byte_in;
    input  wire [7:0]  z_byte_in;
    input  wire [2:0]  level_hit;
    input  wire [2:0]  pulse_hit;
    input  wire        pulse_is_double;
    input  wire        trim_parity_fault;
    input  wire [7:0]  otp_user_byte;
    input  wire [7:0]  otp_ident_byte;
    output reg         int_a_pin_r;
    output reg         int_b_pin_r;
    output reg         two_wire_off_r;
    output reg         self_test_en_r;
    output reg  [1:0]  mode_sel_r;
    output reg  [10:0] x_trim_r;
    output reg  [10:0] y_trim_r;
    output reg  [10:0] z_trim_r;

    // ------------------------------------------------------------
    // Access qualification
    // ------------------------------------------------------------
    // Two-wire traffic is dropped outright while disabled
    wire       acc_ok = ~(reg_two_wire & two_wire_off_r);
    wire       wr_ok  = reg_wr & acc_ok;
    wire       rd_ok  = reg_rd & acc_ok;

    wire       rd_xl  = rd_ok && (reg_addr == `ASR_X_SAMPLE_LOW);
    wire       rd_xh  = rd_ok && (reg_addr == `ASR_X_SAMPLE_HIGH);
    wire       rd_yl  = rd_ok && (reg_addr == `ASR_Y_SAMPLE_LOW);
    wire       rd_yh  = rd_ok && (reg_addr == `ASR_Y_SAMPLE_HIGH);
    wire       rd_zl  = rd_ok && (reg_addr == `ASR_Z_SAMPLE_LOW);
    wire       rd_zh  = rd_ok && (reg_addr == `ASR_Z_SAMPLE_HIGH);
    // Any read of sample data consumes the ready state
    wire       rd_smp = rd_ok && (reg_addr <= `ASR_Z_SAMPLE_BYTE);

    // ------------------------------------------------------------
    // Axis sample stores
    // ------------------------------------------------------------
    wire [7:0] x_low_byte;
    wire [7:0] x_high_byte;
    wire [7:0] x_short;
    wire [7:0] y_low_byte;
    wire [7:0] y_high_byte;
    wire [7:0] y_short;
    wire [7:0] z_low_byte;
    wire [7:0] z_high_byte;
    wire [7:0] z_short;

    // Coherence holds until the host reads the high byte of the same axis
    asr_axis_hold u_x_axis
    (
        .core_clk    (core_clk),
        .reset_n     (reset_n),
        .sample_load (sample_valid),
        .sample_in   (x_sample),
        .byte_in     (x_byte_in),
        .low_read    (rd_xl),
        .high_read   (rd_xh),
        .low_byte    (x_low_byte),
        .high_byte   (x_high_byte),
        .short_byte  (x_short)
    );

    asr_axis_hold u_y_axis
    (
        .core_clk    (core_clk),
        .reset_n     (reset_n),
        .sample_load (sample_valid),
        .sample_in   (y_sample),
        .byte_in     (y_byte_in),
        .low_read    (rd_yl),
        .high_read   (rd_yh),
        .low_byte    (y_low_byte),
        .high_byte   (y_high_byte),
        .short_byte  (y_short)
    );

    asr_axis_hold u_z_axis
    (
        .core_clk    (core_clk),
        .reset_n     (reset_n),
        .sample_load (sample_valid),
        .sample_in   (z_sample),
        .byte_in     (z_byte_in),
        .low_read    (rd_zl),
        .high_read   (rd_zh),
        .low_byte    (z_low_byte),
        .high_byte   (z_high_byte),
        .short_byte  (z_short)
    );

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    reg  [6:0] mode_ctl_r;
    reg  [7:0] ctl_one_r;
    wire [1:0] route = ctl_one_r[`ASR_CTL_ROUTE_LSB+1:`ASR_CTL_ROUTE_LSB];
    wire       ready_pin_mask = mode_ctl_r[`ASR_MC_READY_MASK_BIT];

    always @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            mode_ctl_r     <= 7'h00;
            ctl_one_r      <= 8'h00;
            two_wire_off_r <= 1'b0;
            x_trim_r       <= 11'h000;
            y_trim_r       <= 11'h000;
            z_trim_r       <= 11'h000;
        end
        else if (wr_ok)
        begin
            // Trim LSB is a half count, the value is passed on unscaled
            if (reg_addr == `ASR_X_TRIM_LOW)
            begin
                x_trim_r[7:0] <= reg_wdata;
            end
            else if (reg_addr == `ASR_X_TRIM_HIGH)
            begin
                x_trim_r[10:8] <= reg_wdata[2:0];
            end
            else if (reg_addr == `ASR_Y_TRIM_LOW)
            begin
                y_trim_r[7:0] <= reg_wdata;
            end
            else if (reg_addr == `ASR_Y_TRIM_HIGH)
            begin
                y_trim_r[10:8] <= reg_wdata[2:0];
            end
            else if (reg_addr == `ASR_Z_TRIM_LOW)
            begin
                z_trim_r[7:0] <= reg_wdata;
            end
            else if (reg_addr == `ASR_Z_TRIM_HIGH)
            begin
                z_trim_r[10:8] <= reg_wdata[2:0];
            end
            else if (reg_addr == `ASR_BUS_ADDRESS)
            begin
                two_wire_off_r <= reg_wdata[`ASR_BA_OFF_BIT];
            end
            else if (reg_addr == `ASR_MODE_CONTROL)
            begin
                mode_ctl_r <= reg_wdata[6:0];
            end
            else if (reg_addr == `ASR_CONTROL_ONE)
            begin
                ctl_one_r <= reg_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Status and event sources
    // ------------------------------------------------------------
    reg        ready_r;
    reg        over_r;
    reg  [2:0] level_r;
    reg  [2:0] pulse_r;
    reg        flag_a_r;
    reg        flag_b_r;

    wire       clr_wr  = wr_ok && (reg_addr == `ASR_FLAG_CLEAR);
    wire       clr_a   = clr_wr & reg_wdata[`ASR_CLR_A_BIT];
    wire       clr_b   = clr_wr & reg_wdata[`ASR_CLR_B_BIT];
    wire       any_lvl = |level_hit;
    wire       any_pls = |pulse_hit;
    wire       sgl_pls = any_pls & ~pulse_is_double;

    reg        a_src;
    reg        b_src;
    reg        clr_lvl;
    reg        clr_pls;

    always @*
    begin
        // Reserved routing code behaves as the default split
        case (route)
            `ASR_ROUTE_PLS_LVL:
            begin
                a_src   = any_pls;
                b_src   = any_lvl;
                clr_lvl = clr_b;
                clr_pls = clr_a;
            end
            `ASR_ROUTE_SGL_ANY:
            begin
                a_src   = sgl_pls;
                b_src   = any_pls;
                clr_lvl = 1'b0;
                clr_pls = clr_a | clr_b;
            end
            default:
            begin
                a_src   = any_lvl;
                b_src   = any_pls;
                clr_lvl = clr_a;
                clr_pls = clr_b;
            end
        endcase
    end

    // Source flags move only on events or clears, never on reads; ready/over clear on sample reads; set wins, but a sample read blocks the over set
    always @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            ready_r  <= 1'b0;
            over_r   <= 1'b0;
            level_r  <= 3'h0;
            pulse_r  <= 3'h0;
            flag_a_r <= 1'b0;
            flag_b_r <= 1'b0;
        end
        else
        begin
            ready_r <= sample_valid | (ready_r & ~rd_smp);
            over_r  <= (sample_valid & ready_r & ~rd_smp)
                       | (over_r & ~rd_smp);
            level_r <= level_hit | (level_r & {3{~clr_lvl}});
            // Double pulses leave the per-axis flags untouched
            pulse_r <= (pulse_hit & {3{~pulse_is_double}})
                       | (pulse_r & {3{~clr_pls}});
            flag_a_r <= a_src | (flag_a_r & ~clr_a);
            flag_b_r <= b_src | (flag_b_r & ~clr_b);
        end
    end

    wire [7:0] state_byte = {5'h00, trim_parity_fault, over_r, ready_r};
    wire [7:0] source_byte = {level_r[0], level_r[1], level_r[2],
                              pulse_r[0], pulse_r[1], pulse_r[2],
                              flag_b_r, flag_a_r};

    // ------------------------------------------------------------
    // Pins and derived outputs
    // ------------------------------------------------------------
    always @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            int_a_pin_r    <= 1'b0;
            int_b_pin_r    <= 1'b0;
            self_test_en_r <= 1'b0;
            mode_sel_r     <= 2'h0;
        end
        else
        begin
            // Host picks the mask; hardware only obeys it
            int_a_pin_r    <= flag_a_r | (ready_r & ~ready_pin_mask);
            int_b_pin_r    <= flag_b_r;
            // Bad trim data would make self-test results meaningless
            self_test_en_r <= mode_ctl_r[`ASR_MC_SELF_TEST_BIT]
                              & ~trim_parity_fault;
            mode_sel_r     <= mode_ctl_r[1:0];
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    reg  [7:0] rd_mux;

    always @*
    begin
        if (reg_addr == `ASR_X_SAMPLE_LOW)
            rd_mux = x_low_byte;
        else if (reg_addr == `ASR_X_SAMPLE_HIGH)
            rd_mux = x_high_byte;
        else if (reg_addr == `ASR_Y_SAMPLE_LOW)
            rd_mux = y_low_byte;
        else if (reg_addr == `ASR_Y_SAMPLE_HIGH)
            rd_mux = y_high_byte;
        else if (reg_addr == `ASR_Z_SAMPLE_LOW)
            rd_mux = z_low_byte;
        else if (reg_addr == `ASR_Z_SAMPLE_HIGH)
            rd_mux = z_high_byte;
        else if (reg_addr == `ASR_X_SAMPLE_BYTE)
            rd_mux = x_short;
        else if (reg_addr == `ASR_Y_SAMPLE_BYTE)
            rd_mux = y_short;
        else if (reg_addr == `ASR_Z_SAMPLE_BYTE)
            rd_mux = z_short;
        else if (reg_addr == `ASR_SAMPLE_STATE)
            rd_mux = state_byte;
        else if (reg_addr == `ASR_EVENT_SOURCE)
            rd_mux = source_byte;
        else if (reg_addr == `ASR_BUS_ADDRESS)
            rd_mux = {two_wire_off_r, `ASR_SLAVE_ADDR_RST};
        else if (reg_addr == `ASR_USER_INFO)
            rd_mux = otp_user_byte;
        else if (reg_addr == `ASR_PART_IDENT)
            rd_mux = otp_ident_byte;
        else if (reg_addr == `ASR_X_TRIM_LOW)
            rd_mux = x_trim_r[7:0];
        else if (reg_addr == `ASR_X_TRIM_HIGH)
            rd_mux = {5'h00, x_trim_r[10:8]};
        else if (reg_addr == `ASR_Y_TRIM_LOW)
            rd_mux = y_trim_r[7:0];
        else if (reg_addr == `ASR_Y_TRIM_HIGH)
            rd_mux = {5'h00, y_trim_r[10:8]};
        else if (reg_addr == `ASR_Z_TRIM_LOW)
            rd_mux = z_trim_r[7:0];
        else if (reg_addr == `ASR_Z_TRIM_HIGH)
            rd_mux = {5'h00, z_trim_r[10:8]};
        else if (reg_addr == `ASR_MODE_CONTROL)
            rd_mux = {1'b0, mode_ctl_r};
        else if (reg_addr == `ASR_CONTROL_ONE)
            rd_mux = ctl_one_r;
        else
            rd_mux = 8'h00;
    end

    always @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            reg_rdata_r  <= 8'h00;
            reg_rvalid_r <= 1'b0;
        end
        else
        begin
            reg_rvalid_r <= rd_ok;
            if (rd_ok)
            begin
                reg_rdata_r <= rd_mux;
            end
        end
    end

endmodule // asr_sample_regs

/* File: verification/asr_sample_regs_asserts.sv */
`timescale 1ns/1ps

// --------
// Register port checks
// --------
module asr_sample_regs_chk
(
    input logic        core_clk,
    input logic        reset_n,
    input logic [7:0]  reg_addr,
    input logic        reg_wr,
    input logic        reg_rd,
    input logic [7:0]  reg_wdata,
    input logic        reg_two_wire,
    input logic [7:0]  reg_rdata_r,
    input logic        reg_rvalid_r,
    input logic        sample_valid,
    input logic        trim_parity_fault,
    input logic [7:0]  otp_ident_byte,
    input logic        two_wire_off_r,
    input logic        self_test_en_r,
    input logic [10:0] x_trim_r
);
    // Two-wire cycles while disabled are no access at all
    wire acc_rd = reg_rd && !(reg_two_wire && two_wire_off_r);
    wire acc_wr = reg_wr && !(reg_two_wire && two_wire_off_r);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    a_read_answered: assert property (
        acc_rd |=> reg_rvalid_r)
        else $error("accepted read got no answer");
    a_refused_read: assert property (
        reg_rd && !acc_rd |=> !reg_rvalid_r)
        else $error("refused read answered");
    a_status_spare: assert property (
        acc_rd && reg_addr == 8'h09 |=> reg_rdata_r[7:3] == 5'h00)
        else $error("status spare bits not zero");
    a_ready_seen: assert property (
        acc_rd && reg_addr == 8'h09 && $past(sample_valid) && $past(reset_n) |=> reg_rdata_r[0])
        else $error("ready flag missing");
    a_parity_seen: assert property (
        acc_rd && reg_addr == 8'h09 |=> reg_rdata_r[2] == $past(trim_parity_fault))
        else $error("parity flag wrong");
    a_parity_blocks: assert property (
        trim_parity_fault |=> !self_test_en_r)
        else $error("self-test not blocked");
    a_addr_fixed: assert property (
        acc_rd && reg_addr == 8'h0d |=> reg_rdata_r[6:0] == 7'h1d)
        else $error("address bits changed");
    a_off_bit: assert property (
        acc_wr && reg_addr == 8'h0d |=> two_wire_off_r == $past(reg_wdata[7]))
        else $error("disable bit not written");
    a_ident_byte: assert property (
        acc_rd && reg_addr == 8'h0f |=> reg_rdata_r == $past(otp_ident_byte))
        else $error("identity byte mismatch");
    a_trim_low: assert property (
        acc_wr && reg_addr == 8'h10 |=> x_trim_r[7:0] == $past(reg_wdata))
        else $error("trim low byte not stored");
    a_reset_clean: assert property (disable iff (1'b0)
        $rose(reset_n) |-> !reg_rvalid_r && !two_wire_off_r && x_trim_r == 11'h000)
        else $error("outputs not reset");
endmodule // asr_sample_regs_chk

/* File: verification/asr_host_model.sv */
`timescale 1ns/1ps

// --------
// Host controller on the register port
// --------
module asr_host_model
(
    input  logic       core_clk,
    output logic [7:0] reg_addr,
    output logic       reg_wr,
    output logic       reg_rd,
    output logic [7:0] reg_wdata,
    output logic       reg_two_wire,
    input  logic [7:0] reg_rdata_r,
    input  logic       reg_rvalid_r
);
    initial
    begin
        reg_addr     = 8'h00;
        reg_wr       = 1'b0;
        reg_rd       = 1'b0;
        reg_wdata    = 8'h00;
        reg_two_wire = 1'b0;
    end

    // Released lines show the inverse
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic tw);
        @(negedge core_clk);
        reg_addr     = a;
        reg_wdata    = d;
        reg_two_wire = tw;
        reg_wr       = 1'b1;
        @(negedge core_clk);
        reg_wr       = 1'b0;
        reg_addr     = ~a;
        reg_wdata    = ~d;
    endtask

    task automatic rd(input logic [7:0] a, input logic tw, output logic [7:0] d, output logic v);
        @(negedge core_clk);
        reg_addr     = a;
        reg_two_wire = tw;
        reg_rd       = 1'b1;
        @(negedge core_clk);
        d            = reg_rdata_r;
        v            = reg_rvalid_r;
        reg_rd       = 1'b0;
        reg_addr     = ~a;
    endtask

    // High byte straight after its low byte, nothing in between
    task automatic pair(input logic [1:0] ax, output logic [7:0] lo, output logic [7:0] hi);
        logic v;
        rd({5'h0, ax, 1'b0}, 1'b0, lo, v);
        rd({5'h0, ax, 1'b1}, 1'b0, hi, v);
    endtask
endmodule // asr_host_model

/* File: verification/asr_sample_regs_test.sv */
`timescale 1ns/1ps

// --------
// Bench
// --------
module asr_sample_regs_test;
    logic        core_clk, reset_n, sample_valid, pulse_is_double, trim_parity_fault;
    logic        reg_wr, reg_rd, reg_two_wire, reg_rvalid_r, v, par, r;
    logic        int_a_pin_r, int_b_pin_r, two_wire_off_r, self_test_en_r;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata_r, d, hi, e, otp_user_byte, otp_ident_byte;
    logic [9:0]  smp [3];
    logic [7:0]  byt [3];
    logic [2:0]  level_hit, pulse_hit;
    logic [1:0]  mode_sel_r, ax;
    logic [10:0] x_trim_r, y_trim_r, z_trim_r, tr;
    logic [9:0]  old;
    logic [31:0] lf;
    int          failures;
    int          n_checks;

    asr_sample_regs asr_sample_regs_inst
    (
        .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_two_wire(reg_two_wire),
        .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r), .sample_valid(sample_valid),
        .x_sample(smp[0]), .y_sample(smp[1]), .z_sample(smp[2]), .x_byte_in(byt[0]),
        .y_byte_in(byt[1]), .z_byte_in(byt[2]), .level_hit(level_hit), .pulse_hit(pulse_hit),
        .pulse_is_double(pulse_is_double), .trim_parity_fault(trim_parity_fault),
        .otp_user_byte(otp_user_byte), .otp_ident_byte(otp_ident_byte),
        .int_a_pin_r(int_a_pin_r), .int_b_pin_r(int_b_pin_r), .two_wire_off_r(two_wire_off_r),
        .self_test_en_r(self_test_en_r), .mode_sel_r(mode_sel_r), .x_trim_r(x_trim_r),
        .y_trim_r(y_trim_r), .z_trim_r(z_trim_r)
    );

    asr_host_model asr_host_model_inst
    (
        .core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_two_wire(reg_two_wire), .reg_rdata_r(reg_rdata_r),
        .reg_rvalid_r(reg_rvalid_r)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // --------
    // Expectations and helpers
    // --------
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [7:0] exp_rst(input logic [7:0] a);
        case (a)
            8'h0d:   return 8'h1d;
            8'h0e:   return otp_user_byte;
            8'h0f:   return otp_ident_byte;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] exp_src(input logic [2:0] lh, input logic [2:0] ph, input logic rt);
        return {lh[0], lh[1], lh[2], ph[0], ph[1], ph[2], rt ? |lh : |ph, rt ? |ph : |lh};
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        asr_host_model_inst.rd(a, 1'b0, d, v);
        chk({7'h0, v}, 8'h01);
        chk(d, exp);
    endtask

    task automatic w(input logic [7:0] a, d);
        asr_host_model_inst.wr(a, d, 1'b0);
    endtask

    task automatic load();
        @(negedge core_clk);
        for (int k = 0; k < 3; k++)
        begin
            lf = nxt(lf);
            smp[k] = lf[9:0];
            byt[k] = lf[19:12];
        end
        sample_valid = 1'b1;
        @(negedge core_clk);
        sample_valid = 1'b0;
    endtask

    task automatic evt(input logic [2:0] lh, input logic [2:0] ph);
        @(negedge core_clk);
        level_hit = lh;
        pulse_hit = ph;
        @(negedge core_clk);
        level_hit = 3'h0;
        pulse_hit = 3'h0;
    endtask

    task automatic end_sim();
        if (failures == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // --------
    // Main sequence
    // --------
    initial
    begin
        failures = 0;
        n_checks = 0;
        lf = 32'ha3e2;
        reset_n = 1'b0;
        sample_valid = 1'b0;
        smp = '{10'h000, 10'h000, 10'h000};
        byt = '{8'h00, 8'h00, 8'h00};
        level_hit = 3'h0;
        pulse_hit = 3'h0;
        pulse_is_double = 1'b0;
        trim_parity_fault = 1'b0;
        otp_user_byte = 8'h5a;
        otp_ident_byte = 8'hc3; // Arbitrary programmed value
        repeat (12) @(negedge core_clk);
        reset_n = 1'b1;
        for (int a = 0; a < 17; a++)
            rdc(8'(a), exp_rst(8'(a)));
        for (int i = 0; i < 12; i++)
        begin
            ax = 2'(i % 3);
            lf = nxt(lf);
            par = lf[3];
            trim_parity_fault = par;
            w(8'h16, 8'h13);
            @(negedge core_clk);
            chk({5'h0, mode_sel_r, self_test_en_r}, {5'h0, 2'h3, ~par});
            load();
            rdc(8'h09, {5'h0, par, 2'b01});
            chk({7'h0, int_a_pin_r}, 8'h01);
            old = smp[ax];
            // New sample between low and high read
            fork
                asr_host_model_inst.pair(ax, d, hi);
                begin
                    repeat (2) @(negedge core_clk);
                    smp[ax] = {~old[9:8], old[7:0] ^ 8'h3c};
                    sample_valid = 1'b1;
                    @(negedge core_clk);
                    sample_valid = 1'b0;
                end
            join
            chk(d, old[7:0]);
            chk(hi, {6'h0, old[9:8]});
            rdc({5'h0, ax, 1'b1}, {6'h0, ~old[9:8]});
            rdc(8'h09, {5'h0, par, 2'b00});
            load();
            load();
            rdc(8'h09, {5'h0, par, 2'b11});
            rdc(8'h09, {5'h0, par, 2'b11});
            rdc(8'h06 + {6'h0, ax}, byt[ax]);
            rdc(8'h09, {5'h0, par, 2'b00});
        end
        w(8'h16, 8'h40);
        load();
        for (int i = 0; i < 8; i++)
        begin
            r = i[0];
            w(8'h18, {6'h0, r, 1'b0});
            w(8'h17, 8'h03);
            lf = nxt(lf);
            evt(lf[2:0], lf[5:3]);
            w(8'h17, 8'h00);
            e = exp_src(lf[2:0], lf[5:3], r);
            rdc(8'h0a, e);
            chk({7'h0, int_a_pin_r}, {7'h0, e[0]});
            chk({7'h0, int_b_pin_r}, {7'h0, e[1]});
            w(8'h17, 8'h01);
            rdc(8'h0a, exp_src(r ? lf[2:0] : 3'h0, r ? 3'h0 : lf[5:3], r));
            w(8'h17, 8'h02);
            rdc(8'h0a, 8'h00);
        end
        w(8'h18, 8'h04);
        pulse_is_double = 1'b1;
        evt(3'h0, 3'h5);
        rdc(8'h0a, 8'h02);
        w(8'h17, 8'h02);
        rdc(8'h0a, 8'h00);
        w(8'h0d, 8'h80);
        chk({7'h0, two_wire_off_r}, 8'h01);
        asr_host_model_inst.rd(8'h0d, 1'b1, d, v);
        chk({7'h0, v}, 8'h00);
        asr_host_model_inst.wr(8'h0d, 8'h00, 1'b1);
        rdc(8'h0d, 8'h9d);
        w(8'h0d, 8'h7f);
        rdc(8'h0d, 8'h1d);
        asr_host_model_inst.rd(8'h0d, 1'b1, d, v);
        chk({7'h0, v}, 8'h01);
        for (int k = 0; k < 3; k++)
        begin
            lf = nxt(lf);
            w(8'h10 + 8'(2 * k), lf[7:0]);
            w(8'h11 + 8'(2 * k), lf[15:8]);
            tr = (k == 0) ? x_trim_r : ((k == 1) ? y_trim_r : z_trim_r);
            chk(tr[7:0], lf[7:0]);
            chk({5'h0, tr[10:8]}, {5'h0, lf[10:8]});
            rdc(8'h10 + 8'(2 * k), lf[7:0]);
        end
        end_sim();
    end
endmodule // asr_sample_regs_test

bind asr_sample_regs asr_sample_regs_chk asr_sample_regs_chk_inst
(
    .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_two_wire(reg_two_wire),
    .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r), .sample_valid(sample_valid),
    .trim_parity_fault(trim_parity_fault), .otp_ident_byte(otp_ident_byte),
    .two_wire_off_r(two_wire_off_r), .self_test_en_r(self_test_en_r), .x_trim_r(x_trim_r)
);
